// ### udr_pkg.sv
package udr_pkg;
    // Data width of the parallel bus
    localparam int DATA_W = 8;
    // Register address width
    localparam int ADDR_W = 3;
    // Fifo control register offset and its field positions
    localparam logic [2:0] FCR_OFFSET = 3'h2;
    localparam int FIFO_ENABLE_POS = 0;
    localparam int DMA_MODE_POS = 3;
    // Data register offset (receive read, transmit write)
    localparam logic [2:0] DATA_OFFSET = 3'h0;
    // Value of the fifo control register after reset
    localparam logic [7:0] FCR_RESET = 8'h00;
    // Fifo depth and default receive trigger level
    localparam int FIFO_DEPTH = 16;
    localparam logic [4:0] RX_TRIGGER_RESET = 5'h01;
    // Serial idle level after reset
    localparam logic SERIAL_IDLE = 1'b1;
    // Synchronised strobe pins after reset: select off, low-active strobes high
    localparam logic [4:0] PIN_IDLE = 5'h0a;
    // Last count of the host setup, strobe and hold phases
    localparam logic [2:0] SETUP_LAST = 3'h3;
    localparam logic [2:0] STROBE_LAST = 3'h7;
    localparam logic [2:0] HOLD_LAST = 3'h3;
endpackage

// ### udr_if.sv
`timescale 1ns/100ps
interface udr_if;
    // Parallel bus from the host
    logic chip_select;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic write_strobe_low;
    logic write_strobe_high;
    logic read_strobe_low;
    logic read_strobe_high;
    // DMA request lines from the device
    logic rx_dma_request_n;
    logic tx_dma_request_n;
    // Serial lines
    logic serial_out;
    logic serial_in;

    // The device end
    modport device (
        input chip_select, addr, wdata, write_strobe_low, write_strobe_high,
        input read_strobe_low, read_strobe_high, serial_in,
        output rdata, rx_dma_request_n, tx_dma_request_n, serial_out
    );
    // The host and DMA controller end
    modport host (
        output chip_select, addr, wdata, write_strobe_low, write_strobe_high,
        output read_strobe_low, read_strobe_high, serial_in,
        input rdata, rx_dma_request_n, tx_dma_request_n, serial_out
    );
endinterface

// ### udr_device.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Fifo mode: bit 3 picks DMA type
// - Character mode forces DMA mode 0
// - Mode 0: one transfer per request
// - Mode 1 receive: burst until fifo empty
// - Mode 1 transmit: burst until fifo full
// - Receive mode 0: low when any character
// - Receive mode 0: high when none remain
// - Receive mode 1: low at trigger/time-out
// - Receive mode 1: high once fifo empty
// - Reset drives serial output high
// - Write when selected and either strobe active
// - Host uses one write strobe only
// - Read when selected and either strobe active
module udr_device #(
    parameter int DEPTH = udr_pkg::FIFO_DEPTH
) (
    udr_if.device bus,
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char,
    input wire logic rx_timeout,
    input wire logic [4:0] rx_trigger,
    input wire logic tx_char_take,
    output logic [7:0] tx_char,
    output logic tx_char_valid,
    output logic serial_out_level
);
    localparam int CW = $clog2(DEPTH + 1);

    ////////////////////////////////////////////////////////////////
    // Pin synchronisers for the bus strobes
    logic [4:0] pin_s1_reg;
    logic [4:0] pin_s2_reg;
    logic [4:0] pin_s3_reg;
    wire [4:0] pin_raw = {bus.chip_select, bus.write_strobe_low, bus.write_strobe_high,
                          bus.read_strobe_low, bus.read_strobe_high};

    // Two-stage sync plus an edge-history stage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_reg <= udr_pkg::PIN_IDLE;
            pin_s2_reg <= udr_pkg::PIN_IDLE;
            pin_s3_reg <= udr_pkg::PIN_IDLE;
        end else if (clk_en) begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    // Strobe decode: either polarity counts while selected
    wire cs_s = pin_s2_reg[4];
    wire wr_act = cs_s & (~pin_s2_reg[3] | pin_s2_reg[2]);
    wire wr_was = pin_s3_reg[4] & (~pin_s3_reg[3] | pin_s3_reg[2]);
    wire rd_act = cs_s & (~pin_s2_reg[1] | pin_s2_reg[0]);
    wire rd_was = pin_s3_reg[4] & (~pin_s3_reg[1] | pin_s3_reg[0]);
    wire wr_pulse = wr_act & ~wr_was;
    wire rd_pulse = rd_act & ~rd_was;
    wire wr_fcr = wr_pulse & (bus.addr == udr_pkg::FCR_OFFSET);
    wire wr_data = wr_pulse & (bus.addr == udr_pkg::DATA_OFFSET);
    wire rd_data = rd_pulse & (bus.addr == udr_pkg::DATA_OFFSET);

    ////////////////////////////////////////////////////////////////
    // Fifo control register and derived mode
    logic [7:0] fcr_reg;
    wire fifo_en = fcr_reg[udr_pkg::FIFO_ENABLE_POS];
    wire dma_mode1 = fifo_en & fcr_reg[udr_pkg::DMA_MODE_POS];

    // Register writes to the control register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fcr_reg <= udr_pkg::FCR_RESET;
        end else if (clk_en && wr_fcr) begin
            fcr_reg <= bus.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Receive store; holding register is depth one in character mode
    logic [7:0] rx_mem [DEPTH];
    logic [CW-1:0] rx_cnt_reg;
    logic [$clog2(DEPTH)-1:0] rx_wp_reg;
    logic [$clog2(DEPTH)-1:0] rx_rp_reg;
    wire [CW-1:0] rx_cap = fifo_en ? CW'(DEPTH) : CW'(1);
    wire rx_push = rx_char_valid & (rx_cnt_reg < rx_cap);
    wire rx_pop = rd_data & (rx_cnt_reg != '0);

    // Receive pointers and count
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_cnt_reg <= '0;
            rx_wp_reg <= '0;
            rx_rp_reg <= '0;
        end else if (clk_en) begin
            if (rx_push) begin
                rx_wp_reg <= rx_wp_reg + 1'b1;
            end
            if (rx_pop) begin
                rx_rp_reg <= rx_rp_reg + 1'b1;
            end
            rx_cnt_reg <= rx_cnt_reg + CW'(rx_push) - CW'(rx_pop);
        end
    end

    // Receive storage array, no reset needed
    always_ff @(posedge sys_clk) begin
        if (clk_en && rx_push) begin
            rx_mem[rx_wp_reg] <= rx_char;
        end
    end

    // Read data latched on any read: control register at its offset, receive data otherwise, zero when the receive store is empty
    logic [7:0] rdata_reg;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else if (clk_en && rd_pulse) begin
            rdata_reg <= (bus.addr == udr_pkg::FCR_OFFSET) ? fcr_reg :
                         (rx_cnt_reg != '0) ? rx_mem[rx_rp_reg] : 8'h00;
        end
    end
    assign bus.rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////
    // Receive DMA request
    logic rx_req_reg;
    wire rx_any = (rx_cnt_reg != '0);
    wire rx_hit = (rx_cnt_reg >= rx_trigger) | rx_timeout;

    // Mode 0 follows occupancy; mode 1 sets at trigger and clears when empty
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_req_reg <= 1'b0;
        end else if (clk_en) begin
            if (!dma_mode1) begin
                rx_req_reg <= rx_any;
            end else if (rx_hit && rx_any) begin
                rx_req_reg <= 1'b1;
            end else if (!rx_any) begin
                rx_req_reg <= 1'b0;
            end
        end
    end
    assign bus.rx_dma_request_n = ~rx_req_reg;

    ////////////////////////////////////////////////////////////////
    // Transmit store
    logic [7:0] tx_mem [DEPTH];
    logic [CW-1:0] tx_cnt_reg;
    logic [$clog2(DEPTH)-1:0] tx_wp_reg;
    logic [$clog2(DEPTH)-1:0] tx_rp_reg;
    wire [CW-1:0] tx_cap = fifo_en ? CW'(DEPTH) : CW'(1);
    wire tx_push = wr_data & (tx_cnt_reg < tx_cap);
    wire tx_pop = tx_char_take & (tx_cnt_reg != '0);

    // Transmit pointers and count
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_cnt_reg <= '0;
            tx_wp_reg <= '0;
            tx_rp_reg <= '0;
        end else if (clk_en) begin
            if (tx_push) begin
                tx_wp_reg <= tx_wp_reg + 1'b1;
            end
            if (tx_pop) begin
                tx_rp_reg <= tx_rp_reg + 1'b1;
            end
            tx_cnt_reg <= tx_cnt_reg + CW'(tx_push) - CW'(tx_pop);
        end
    end

    // Transmit storage array
    always_ff @(posedge sys_clk) begin
        if (clk_en && tx_push) begin
            tx_mem[tx_wp_reg] <= bus.wdata;
        end
    end
    assign tx_char = tx_mem[tx_rp_reg];
    assign tx_char_valid = (tx_cnt_reg != '0);

    ////////////////////////////////////////////////////////////////
    // Transmit DMA request
    logic tx_req_reg;

    // Mode 0 asks while empty; mode 1 asks until the fifo is full
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_req_reg <= 1'b1;
        end else if (clk_en) begin
            if (!dma_mode1) begin
                tx_req_reg <= (tx_cnt_reg == '0);
            end else if (tx_cnt_reg == '0) begin
                tx_req_reg <= 1'b1;
            end else if (tx_cnt_reg == CW'(DEPTH)) begin
                tx_req_reg <= 1'b0;
            end
        end
    end
    assign bus.tx_dma_request_n = ~tx_req_reg;

    ////////////////////////////////////////////////////////////////
    // Serial output level, idle after reset
    logic serial_out_reg;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_out_reg <= udr_pkg::SERIAL_IDLE;
        end else if (clk_en) begin
            serial_out_reg <= ~tx_char_valid | tx_char[0];
        end
    end
    assign bus.serial_out = serial_out_reg;
    assign serial_out_level = serial_out_reg;
endmodule // udr_device

// ### udr_host.sv
`timescale 1ns/100ps
module udr_host (
    udr_if.host bus,
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [2:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic use_high_strobes,
    output logic req_ready,
    output logic [7:0] resp_rdata,
    output logic resp_valid,
    output logic rx_dma_pending,
    output logic tx_dma_pending
);
    // Phase of one bus cycle
    typedef enum logic [1:0] {UDH_IDLE, UDH_SETUP, UDH_STROBE, UDH_HOLD} udr_state_t;
    udr_state_t st_reg;
    logic [2:0] cnt_reg;
    logic wr_reg;
    logic hi_reg;
    logic [2:0] addr_reg;
    logic [7:0] wdata_reg;
    logic [7:0] rdata_reg;
    logic rv_reg;
    logic [1:0] rq_s1_reg;
    logic [1:0] rq_s2_reg;

    // Strobes active only in strobe phase; unused strobe held inactive
    wire strobe_on = (st_reg == UDH_STROBE);
    assign bus.chip_select = (st_reg != UDH_IDLE);
    assign bus.addr = addr_reg;
    assign bus.wdata = wdata_reg;
    assign bus.write_strobe_low = ~(strobe_on & wr_reg & ~hi_reg);
    assign bus.write_strobe_high = strobe_on & wr_reg & hi_reg;
    assign bus.read_strobe_low = ~(strobe_on & ~wr_reg & ~hi_reg);
    assign bus.read_strobe_high = strobe_on & ~wr_reg & hi_reg;
    assign bus.serial_in = 1'b1;
    assign req_ready = (st_reg == UDH_IDLE);
    assign resp_rdata = rdata_reg;
    assign resp_valid = rv_reg;
    assign rx_dma_pending = ~rq_s2_reg[0];
    assign tx_dma_pending = ~rq_s2_reg[1];

    ////////////////////////////////////////////////////////////////
    // One access per request; setup and hold last four cycles, strobe eight, for the sync
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= UDH_IDLE;
            cnt_reg <= 3'h0;
            wr_reg <= 1'b0;
            hi_reg <= 1'b0;
            addr_reg <= 3'h0;
            wdata_reg <= 8'h00;
            rdata_reg <= 8'h00;
            rv_reg <= 1'b0;
            rq_s1_reg <= 2'h3;
            rq_s2_reg <= 2'h3;
        end else if (clk_en) begin
            rq_s1_reg <= {bus.tx_dma_request_n, bus.rx_dma_request_n};
            rq_s2_reg <= rq_s1_reg;
            rv_reg <= 1'b0;
            cnt_reg <= cnt_reg + 3'h1;
            case (st_reg)
                UDH_IDLE: begin
                    cnt_reg <= 3'h0;
                    if (req_valid) begin
                        st_reg <= UDH_SETUP;
                        wr_reg <= req_write;
                        hi_reg <= use_high_strobes;
                        addr_reg <= req_addr;
                        wdata_reg <= req_wdata;
                    end
                end
                UDH_SETUP: begin
                    if (cnt_reg == udr_pkg::SETUP_LAST) begin
                        st_reg <= UDH_STROBE;
                        cnt_reg <= 3'h0;
                    end
                end
                UDH_STROBE: begin
                    if (cnt_reg == udr_pkg::STROBE_LAST) begin
                        st_reg <= UDH_HOLD;
                        cnt_reg <= 3'h0;
                        rdata_reg <= bus.rdata;
                        rv_reg <= ~wr_reg;
                    end
                end
                UDH_HOLD: begin
                    if (cnt_reg == udr_pkg::HOLD_LAST) begin
                        st_reg <= UDH_IDLE;
                    end
                end
                default: st_reg <= UDH_IDLE;
            endcase
        end
    end
endmodule // udr_host

// ### udr_checker.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Watches the bus and request lines between the host and device ends
module udr_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic chip_select,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic write_strobe_low,
    input wire logic write_strobe_high,
    input wire logic read_strobe_low,
    input wire logic read_strobe_high,
    input wire logic rx_dma_request_n,
    input wire logic tx_dma_request_n,
    input wire logic serial_out
);
    // Either strobe form counts as active
    wire logic wr_act = !write_strobe_low || write_strobe_high;
    wire logic rd_act = !read_strobe_low || read_strobe_high;
    // Copy of the fifo control value as written on the bus
    logic [7:0] fcr_reg;
    wire logic burst_mode = fcr_reg[udr_pkg::FIFO_ENABLE_POS] && fcr_reg[udr_pkg::DMA_MODE_POS];
    // Tracks control writes so the transmit check knows the mode
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fcr_reg <= udr_pkg::FCR_RESET;
        end else if (wr_act && chip_select && addr == udr_pkg::FCR_OFFSET) begin
            fcr_reg <= wdata;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    reset_idle_a: assert property (
        $rose(rst_n) |-> serial_out && rx_dma_request_n && !tx_dma_request_n)
        else $error("idle levels wrong after reset");
    one_wr_strobe_a: assert property (
        !(!write_strobe_low && write_strobe_high)) else $error("both write strobes active");
    one_rd_strobe_a: assert property (
        !(!read_strobe_low && read_strobe_high)) else $error("both read strobes active");
    write_select_a: assert property (wr_act |-> chip_select)
        else $error("write strobe without select");
    read_select_a: assert property (rd_act |-> chip_select && !wr_act)
        else $error("read strobe without select");
    write_hold_a: assert property (
        wr_act && $past(wr_act) |-> $stable(addr) && $stable(wdata))
        else $error("address or data moved under strobe");
    strobe_len_a: assert property ($rose(wr_act) |-> wr_act [*8])
        else $error("write strobe shorter than eight cycles");
    rdata_stand_a: assert property (!rd_act [*4] |=> $stable(rdata))
        else $error("read data moved without a read");
    tx_load_a: assert property (
        $rose(wr_act) && addr == udr_pkg::DATA_OFFSET && !burst_mode
        |-> ##[1:10] tx_dma_request_n) else $error("transmit request stayed low after load");
endmodule // udr_checker

// ### test_uart_dma_ready_signalling.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Host and device ends joined; bench drives both user sides
module test_uart_dma_ready_signalling;
    localparam int DEPTH = 4;
    logic sys_clk, rst_n, req_valid, req_write, use_high_strobes, rx_char_valid;
    logic rx_timeout, tx_char_take, req_ready, resp_valid, tx_char_valid;
    // Device clock enable, host pending flags and the device's serial level copy
    logic clk_en, rx_pend, tx_pend, serial_out_lvl;
    logic [2:0] req_addr;
    logic [7:0] req_wdata, rx_char, tx_char, resp_rdata, c;
    logic [4:0] rx_trigger;
    logic [7:0] exp_q[$];
    logic [7:0] tx_q[$];
    logic [7:0] fcr_list[3] = '{8'h00, 8'h08, 8'h01};
    int err_total, samples_checked, cycles, seed;
    udr_if bus_if();
    udr_device #(.DEPTH(DEPTH)) u_udr_device (.bus(bus_if), .sys_clk(sys_clk), .rst_n(rst_n),
        .clk_en(clk_en), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
        .rx_timeout(rx_timeout), .rx_trigger(rx_trigger), .tx_char_take(tx_char_take),
        .tx_char(tx_char), .tx_char_valid(tx_char_valid), .serial_out_level(serial_out_lvl));
    udr_host u_udr_host (.bus(bus_if), .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .use_high_strobes(use_high_strobes), .req_ready(req_ready),
        .resp_rdata(resp_rdata), .resp_valid(resp_valid), .rx_dma_pending(rx_pend),
        .tx_dma_pending(tx_pend));
    udr_checker u_udr_checker (.sys_clk(sys_clk), .rst_n(rst_n),
        .chip_select(bus_if.chip_select), .addr(bus_if.addr), .wdata(bus_if.wdata),
        .rdata(bus_if.rdata), .write_strobe_low(bus_if.write_strobe_low),
        .write_strobe_high(bus_if.write_strobe_high), .read_strobe_low(bus_if.read_strobe_low),
        .read_strobe_high(bus_if.read_strobe_high), .rx_dma_request_n(bus_if.rx_dma_request_n),
        .tx_dma_request_n(bus_if.tx_dma_request_n), .serial_out(bus_if.serial_out));
    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Compares and counts one value
    task check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Prints the counts and the verdict
    task complete_run;
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One host transfer, strobe form picked at random
    task bus_op(input logic wr, input logic [2:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        use_high_strobes = 1'($random(seed));
        @(negedge sys_clk);
        req_valid = 1'b0;
        while (req_ready !== 1'b1) @(negedge sys_clk);
    endtask
    // One-cycle pulse on a user input
    task automatic pulse(ref logic s);
        @(negedge sys_clk);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
    endtask
    // Lets request lines settle
    task settle;
        repeat (4) @(negedge sys_clk);
    endtask
    task chk_req(input logic rx_e, input logic tx_e, input logic do_tx);
        settle;
        check("rx_request_n", {7'h00, rx_e}, {7'h00, bus_if.rx_dma_request_n});
        check("rx_pending", {7'h00, ~rx_e}, {7'h00, rx_pend});
        if (do_tx) check("tx_request_n", {7'h00, tx_e}, {7'h00, bus_if.tx_dma_request_n});
        if (do_tx) check("tx_pending", {7'h00, ~tx_e}, {7'h00, tx_pend});
    endtask
    // Read results taken in order from the queue
    always @(posedge sys_clk) begin
        if (resp_valid === 1'b1) begin
            check("read_data", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, resp_rdata);
        end
    end
    // Cycle limit
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            $display("ERROR cycle_limit expected %0d seen %0d", 19999, cycles);
            complete_run;
        end
    end
    initial begin
        seed = 74365;
        {rst_n, req_valid, req_write, use_high_strobes, rx_char_valid} = 5'h00;
        {rx_timeout, tx_char_take, req_addr, req_wdata, rx_char} = 21'h000000;
        rx_trigger = 5'h04;
        clk_en = 1'b1;
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        check("serial_out", 8'h01, {7'h00, bus_if.serial_out});
        check("serial_out_level", 8'h01, {7'h00, serial_out_lvl});
        chk_req(1'b1, 1'b0, 1'b1);
        exp_q.push_back(udr_pkg::FCR_RESET);
        bus_op(1'b0, udr_pkg::FCR_OFFSET, 8'h00);
        $display("test reset done");
        foreach (fcr_list[i]) begin
            bus_op(1'b1, udr_pkg::FCR_OFFSET, fcr_list[i]);
            c = 8'($random(seed));
            rx_char = c;
            pulse(rx_char_valid);
            chk_req(1'b0, 1'b0, 1'b1);
            exp_q.push_back(c);
            bus_op(1'b0, udr_pkg::DATA_OFFSET, 8'h00);
            chk_req(1'b1, 1'b0, 1'b0);
            bus_op(1'b1, udr_pkg::DATA_OFFSET, c);
            chk_req(1'b1, 1'b1, 1'b1);
            check("tx_char", c, tx_char);
            pulse(tx_char_take);
            chk_req(1'b1, 1'b0, 1'b1);
        end
        $display("test single transfer done");
        bus_op(1'b1, udr_pkg::FCR_OFFSET, 8'h09);
        for (int i = 0; i < 4; i++) begin
            rx_char = 8'($random(seed));
            exp_q.push_back(rx_char);
            pulse(rx_char_valid);
            chk_req(i != 3, 1'b0, 1'b0);
        end
        for (int i = 0; i < 4; i++) begin
            bus_op(1'b0, udr_pkg::DATA_OFFSET, 8'h00);
            chk_req(i == 3, 1'b0, 1'b0);
        end
        rx_char = 8'($random(seed));
        exp_q.push_back(rx_char);
        pulse(rx_char_valid);
        chk_req(1'b1, 1'b0, 1'b0);
        pulse(rx_timeout);
        chk_req(1'b0, 1'b0, 1'b0);
        bus_op(1'b0, udr_pkg::DATA_OFFSET, 8'h00);
        chk_req(1'b1, 1'b0, 1'b0);
        $display("test burst receive done");
        for (int i = 0; i < DEPTH; i++) begin
            c = 8'($random(seed));
            tx_q.push_back(c);
            bus_op(1'b1, udr_pkg::DATA_OFFSET, c);
            chk_req(1'b1, i == DEPTH - 1, 1'b1);
        end
        bus_op(1'b1, udr_pkg::DATA_OFFSET, 8'hff);
        for (int i = 0; i < DEPTH; i++) begin
            check("tx_char", tx_q.pop_front(), tx_char);
            pulse(tx_char_take);
        end
        chk_req(1'b1, 1'b0, 1'b1);
        check("tx_char_valid", 8'h00, {7'h00, tx_char_valid});
        check("reads_left", 8'h00, 8'(exp_q.size()));
        $display("test burst transmit done");
        // Frozen device must ignore a character and a time-out
        clk_en = 1'b0;
        pulse(rx_char_valid);
        pulse(rx_timeout);
        @(negedge sys_clk);
        clk_en = 1'b1;
        chk_req(1'b1, 1'b0, 1'b1);
        $display("test clock enable done");
        complete_run;
    end
endmodule // test_uart_dma_ready_signalling
